// File: logic/pwmcc_core.sv
// Counter, run control, buffered loading and register file of the pulse width core
// Overview of operation
// RL1: Six raw waves compared from shared counter
// RL2: Pin select bit gates wave onto pin
// RL3: Clear bit zeroes counter then self-clears
// RL4: Run bit starts counter, zero idles
// RL5: Period and duty double buffered
// RL6: Load bit transfers at period end, self-clears
// RL7: Software waits for load before control writes
// RL8: Event flag set at period end, software clears
// RL9: Group mode takes duties from first two
// RL10: Prescaler divides by power of two
// RL11: Clock select: system clock or timer overflow
// RL12: Software clears, programs, then sets run
// RL13: Group mode: 2,4 use 0; 3,5 use 1
// RL14: Shared 16-bit counter, period split in bytes
// RL15: Compare duty; restart at period
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module pwmcc_core (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire pwmcc_pkg::pwmcc_bus_type bus_i,
   output logic [7:0] rdata_o,
   input wire logic timer1_ovf_i,
   input wire logic [5:0] gpio_out_i,
   output logic [5:0] raw_wave_o,
   output logic [5:0] pin_out_o,
   output logic irq_o
);
   import pwmcc_pkg::*;

   // ******************************
   // Registers
   // ******************************
   logic [7:0] ctrl0_reg, ctrl0_next;
   logic [7:0] ctrl1_reg, ctrl1_next;
   logic [7:0] cksrc_reg, cksrc_next;
   logic [7:0] pin_sel_reg, pin_sel_next;
   logic [7:0] irq_stat_reg, irq_stat_next;
   logic [7:0] irq_mask_reg, irq_mask_next;
   logic [15:0] per_buf_reg, per_buf_next;
   logic [15:0] per_act_reg, per_act_next;
   logic [15:0] duty_buf_reg [NUM_CH];
   logic [15:0] duty_buf_next [NUM_CH];
   logic [15:0] duty_act_reg [NUM_CH];
   logic [15:0] duty_act_next [NUM_CH];
   logic [15:0] cnt_reg, cnt_next;
   logic [6:0] pre_reg, pre_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [5:0] wave_reg, wave_next;
   logic ovf_s1_reg, ovf_s2_reg, ovf_s3_reg;
   pwmcc_state_type state_reg, state_next;
   logic src_tick, tick, period_end;
   logic [6:0] div_top;

   function automatic logic wr_hit(input pwmcc_bus_type b, input logic [7:0] a);
      wr_hit = b.wr && (b.addr == a);
   endfunction

   // ******************************
   // Clock source and prescaler
   // ******************************
   // Two-stage synchroniser for the timer overflow
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ovf_s1_reg <= 1'b0;
         ovf_s2_reg <= 1'b0;
         ovf_s3_reg <= 1'b0;
      end else begin
         ovf_s1_reg <= timer1_ovf_i;
         ovf_s2_reg <= ovf_s1_reg;
         ovf_s3_reg <= ovf_s2_reg;
      end
   end

   // Rising edge of the synchronised overflow is one source tick
   always_comb begin
      src_tick = cksrc_reg[BIT_CKS] ? (ovf_s2_reg && !ovf_s3_reg) : 1'b1; // RL11
      div_top = 7'((8'h01 << ctrl1_reg[DIV_LSB +: DIV_W]) - 8'h01); // RL10
      tick = 1'b0;
      pre_next = pre_reg;
      if (state_reg != ST_RUN) begin
         pre_next = PRE_ZERO;
      end else if (src_tick) begin
         if (pre_reg >= div_top) begin
            pre_next = PRE_ZERO;
            tick = 1'b1; // RL10
         end else begin
            pre_next = pre_reg + PRE_ONE;
         end
      end
   end

   // ******************************
   // Counter and control state
   // ******************************
   // Clear state holds the counter at zero for one cycle
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      period_end = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (ctrl0_reg[BIT_CLR]) begin
               state_next = ST_CLEAR;
            end else if (ctrl0_reg[BIT_RUN]) begin
               state_next = ST_RUN; // RL4
            end
         end
         ST_CLEAR: begin
            cnt_next = CNT_ZERO; // RL3
            state_next = ctrl0_reg[BIT_RUN] ? ST_RUN : ST_IDLE;
         end
         ST_RUN: begin
            if (ctrl0_reg[BIT_CLR]) begin
               state_next = ST_CLEAR;
            end else if (!ctrl0_reg[BIT_RUN]) begin
               state_next = ST_IDLE; // RL4
            end else if (tick) begin
               if (cnt_reg >= per_act_reg) begin
                  cnt_next = CNT_ZERO; // RL15
                  period_end = 1'b1;
               end else begin
                  cnt_next = cnt_reg + CNT_ONE; // RL14
               end
            end
         end
      endcase
   end

   // ******************************
   // Active buffers and waves
   // ******************************
   // Buffers move to the active copies only at period end
   always_comb begin
      per_act_next = per_act_reg;
      for (int i = 0; i < NUM_CH; i++) begin
         duty_act_next[i] = duty_act_reg[i];
      end
      if (period_end && ctrl0_reg[BIT_LOAD]) begin
         per_act_next = per_buf_reg; // RL5 RL6
         for (int i = 0; i < NUM_CH; i++) begin
            duty_act_next[i] = duty_buf_reg[i]; // RL5
         end
      end
      // Group mode: upper pairs follow the first two duties
      for (int i = 0; i < NUM_CH; i++) begin
         if (ctrl1_reg[BIT_GROUP] && i >= 2) begin
            wave_next[i] = ctrl0_reg[BIT_RUN] && (cnt_reg < duty_act_reg[i % 2]); // RL9 RL13
         end else begin
            wave_next[i] = ctrl0_reg[BIT_RUN] && (cnt_reg < duty_act_reg[i]); // RL1 RL15
         end
      end
   end

   // ******************************
   // Register writes
   // ******************************
   // Hardware set wins over a software clear in one cycle
   always_comb begin
      ctrl0_next = ctrl0_reg;
      ctrl1_next = ctrl1_reg;
      cksrc_next = cksrc_reg;
      pin_sel_next = pin_sel_reg;
      irq_mask_next = irq_mask_reg;
      irq_stat_next = irq_stat_reg;
      per_buf_next = per_buf_reg;
      for (int i = 0; i < NUM_CH; i++) begin
         duty_buf_next[i] = duty_buf_reg[i];
         if (wr_hit(bus_i, ADDR_DUTY_HI_BASE + 8'(i))) begin
            duty_buf_next[i][15:8] = bus_i.wdata;
         end
         if (wr_hit(bus_i, ADDR_DUTY_LO_BASE + 8'(i))) begin
            duty_buf_next[i][7:0] = bus_i.wdata;
         end
      end
      if (wr_hit(bus_i, ADDR_PER_HI)) begin
         per_buf_next[15:8] = bus_i.wdata; // RL14
      end
      if (wr_hit(bus_i, ADDR_PER_LO)) begin
         per_buf_next[7:0] = bus_i.wdata;
      end
      if (wr_hit(bus_i, ADDR_CTRL1)) begin
         ctrl1_next = bus_i.wdata;
      end
      if (wr_hit(bus_i, ADDR_CLK_SRC)) begin
         cksrc_next = bus_i.wdata & (8'h01 << BIT_CKS);
      end
      if (wr_hit(bus_i, ADDR_PIN_SEL)) begin
         pin_sel_next = bus_i.wdata & 8'h3f;
      end
      if (wr_hit(bus_i, ADDR_IRQ_MASK)) begin
         irq_mask_next = bus_i.wdata & 8'h03;
      end
      if (wr_hit(bus_i, ADDR_IRQ_STAT)) begin
         irq_stat_next = irq_stat_reg & ~bus_i.wdata;
      end
      if (wr_hit(bus_i, ADDR_CTRL0)) begin
         ctrl0_next[BIT_RUN] = bus_i.wdata[BIT_RUN];
         ctrl0_next[BIT_FLAG] = bus_i.wdata[BIT_FLAG] & ctrl0_reg[BIT_FLAG]; // RL8
         if (bus_i.wdata[BIT_LOAD]) begin
            ctrl0_next[BIT_LOAD] = 1'b1; // RL6
         end
         if (bus_i.wdata[BIT_CLR]) begin
            ctrl0_next[BIT_CLR] = 1'b1; // RL3
         end
      end
      if (state_reg == ST_CLEAR) begin
         ctrl0_next[BIT_CLR] = 1'b0; // RL3
      end
      if (period_end && ctrl0_reg[BIT_LOAD]) begin
         ctrl0_next[BIT_LOAD] = 1'b0; // RL6
         irq_stat_next[IRQ_LOADED] = 1'b1;
      end
      if (period_end) begin
         ctrl0_next[BIT_FLAG] = 1'b1; // RL8
         irq_stat_next[IRQ_PERIOD] = 1'b1;
      end
      ctrl0_next[3:0] = 4'h0;
   end

   // ******************************
   // Read mux
   // ******************************
   // Read data stand one cycle, zero otherwise
   always_comb begin
      rdata_next = RESET_BYTE;
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            ADDR_CTRL0: rdata_next = ctrl0_reg;
            ADDR_CTRL1: rdata_next = ctrl1_reg;
            ADDR_CLK_SRC: rdata_next = cksrc_reg;
            ADDR_PER_HI: rdata_next = per_buf_reg[15:8];
            ADDR_PER_LO: rdata_next = per_buf_reg[7:0];
            ADDR_PIN_SEL: rdata_next = pin_sel_reg;
            ADDR_IRQ_STAT: rdata_next = irq_stat_reg;
            ADDR_IRQ_MASK: rdata_next = irq_mask_reg;
            default: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (bus_i.addr == ADDR_DUTY_HI_BASE + 8'(i)) begin
                     rdata_next = duty_buf_reg[i][15:8];
                  end
                  if (bus_i.addr == ADDR_DUTY_LO_BASE + 8'(i)) begin
                     rdata_next = duty_buf_reg[i][7:0];
                  end
               end
            end
         endcase
      end
   end

   // ******************************
   // State registers
   // ******************************
   // Synchronous reset of every state group
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ctrl0_reg <= RESET_BYTE;
         ctrl1_reg <= RESET_BYTE;
         cksrc_reg <= RESET_BYTE;
         pin_sel_reg <= RESET_BYTE;
         irq_stat_reg <= RESET_BYTE;
         irq_mask_reg <= RESET_BYTE;
         per_buf_reg <= CNT_ZERO;
         per_act_reg <= CNT_ZERO;
         cnt_reg <= CNT_ZERO;
         pre_reg <= PRE_ZERO;
         rdata_reg <= RESET_BYTE;
         wave_reg <= 6'h00;
         state_reg <= ST_IDLE;
         for (int i = 0; i < NUM_CH; i++) begin
            duty_buf_reg[i] <= CNT_ZERO;
            duty_act_reg[i] <= CNT_ZERO;
         end
      end else begin
         ctrl0_reg <= ctrl0_next;
         ctrl1_reg <= ctrl1_next;
         cksrc_reg <= cksrc_next;
         pin_sel_reg <= pin_sel_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         per_buf_reg <= per_buf_next;
         per_act_reg <= per_act_next;
         cnt_reg <= cnt_next;
         pre_reg <= pre_next;
         rdata_reg <= rdata_next;
         wave_reg <= wave_next;
         state_reg <= state_next;
         for (int i = 0; i < NUM_CH; i++) begin
            duty_buf_reg[i] <= duty_buf_next[i];
            duty_act_reg[i] <= duty_act_next[i];
         end
      end
   end

   // ******************************
   // Outputs
   // ******************************
   // Pins show the wave only where selected
   assign rdata_o = rdata_reg;
   assign raw_wave_o = wave_reg; // RL1
   assign pin_out_o = (wave_reg & pin_sel_reg[5:0]) | (gpio_out_i & ~pin_sel_reg[5:0]); // RL2
   assign irq_o = |(irq_stat_reg & irq_mask_reg);
endmodule

// File: include/pwmcc_pkg.sv
// Package of constants and types for the pulse width counter control core
package pwmcc_pkg;
   // ******************************
   // Register offsets
   // ******************************
   localparam logic [7:0] ADDR_CLK_SRC = 8'h8e;
   localparam logic [7:0] ADDR_CTRL0 = 8'hd8;
   localparam logic [7:0] ADDR_CTRL1 = 8'hdf;
   localparam logic [7:0] ADDR_PER_HI = 8'hd1;
   localparam logic [7:0] ADDR_PER_LO = 8'hd9;
   localparam logic [7:0] ADDR_DUTY_HI_BASE = 8'hf0;
   localparam logic [7:0] ADDR_DUTY_LO_BASE = 8'hf8;
   localparam logic [7:0] ADDR_PIN_SEL = 8'he0;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'he1;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'he2;
   // ******************************
   // Field positions and reset values
   // ******************************
   localparam int BIT_RUN = 7;
   localparam int BIT_LOAD = 6;
   localparam int BIT_FLAG = 5;
   localparam int BIT_CLR = 4;
   localparam int BIT_GROUP = 5;
   localparam int BIT_CKS = 6;
   localparam int DIV_LSB = 0;
   localparam int DIV_W = 3;
   localparam int NUM_CH = 6;
   localparam int IRQ_PERIOD = 0;
   localparam int IRQ_LOADED = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [6:0] PRE_ZERO = 7'h00;
   localparam logic [6:0] PRE_ONE = 7'h01;

   // Bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pwmcc_bus_type;

   // Control state
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CLEAR = 3'b010,
      ST_RUN = 3'b100
   } pwmcc_state_type;
endpackage

// File: sim/pwmcc_pins_model.sv
// Pin side model that supplies the general purpose output levels
`timescale 1ns/100ps
module pwmcc_pins_model (
   input wire logic ref_clk_i,
   output wire logic [5:0] gpio_out_o
);
   logic [5:0] pat = 6'h2a;
   // Changes every cycle so a stale value never passes
   always @(posedge ref_clk_i) begin
      pat <= pat + 6'h25;
   end
   assign gpio_out_o = pat;
endmodule

// File: sim/pwmcc_core_sva.sv
// Assertion checker of the pulse width counter control core
`timescale 1ns/100ps
module pwmcc_core_sva
   import pwmcc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire pwmcc_pkg::pwmcc_bus_type bus_i,
   input wire logic [7:0] rdata_o,
   input wire logic timer1_ovf_i,
   input wire logic [5:0] gpio_out_i,
   input wire logic [5:0] raw_wave_o,
   input wire logic [5:0] pin_out_o,
   input wire logic irq_o
);
   logic run_sh;
   logic grp_sh;
   logic [5:0] sel_sh;
   logic [1:0] msk_sh;
   logic unm;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   assign unm = bus_i.rd && bus_i.addr == 8'h00;
   // ******************************
   // Register shadows
   // ******************************
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         run_sh <= 1'b0;
         grp_sh <= 1'b0;
         sel_sh <= 6'h00;
         msk_sh <= 2'h0;
      end else if (bus_i.wr) begin
         case (bus_i.addr)
            ADDR_CTRL0: run_sh <= bus_i.wdata[BIT_RUN];
            ADDR_CTRL1: grp_sh <= bus_i.wdata[BIT_GROUP];
            ADDR_PIN_SEL: sel_sh <= bus_i.wdata[5:0];
            ADDR_IRQ_MASK: msk_sh <= bus_i.wdata[1:0];
            default: ;
         endcase
      end
   end
   a_reset_quiet: assert property ($fell(rst_i) |-> raw_wave_o == 6'h00 && !irq_o)
      else $error("outputs not quiet after reset");
   a_idle_low: assert property ((!run_sh) [*3] |-> raw_wave_o == 6'h00)
      else $error("wave while idle");
   a_group_pairs: assert property (grp_sh [*3] |->
      {raw_wave_o[2], raw_wave_o[4], raw_wave_o[3], raw_wave_o[5]} ==
      {raw_wave_o[0], raw_wave_o[0], raw_wave_o[1], raw_wave_o[1]})
      else $error("group waves differ");
   a_pin_select: assert property (
      pin_out_o == ((raw_wave_o & sel_sh) | (gpio_out_i & ~sel_sh)))
      else $error("pin mux wrong");
   a_clear_done: assert property (
      (bus_i.wr && bus_i.addr == ADDR_CTRL0 && bus_i.wdata[BIT_CLR]) ##3
      (bus_i.rd && bus_i.addr == ADDR_CTRL0) |=> !rdata_o[BIT_CLR])
      else $error("clear bit stuck");
   a_rdata_once: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
      else $error("read data outside slot");
   a_unmapped_zero: assert property ($past(unm) |-> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_irq_masked: assert property ((msk_sh == 2'h0) [*2] |-> !irq_o)
      else $error("masked interrupt high");
   c_timer_src: cover property (bus_i.wr && bus_i.addr == ADDR_CLK_SRC && bus_i.wdata[BIT_CKS]);
   c_group: cover property (grp_sh && $rose(raw_wave_o[2]));
   c_irq: cover property ($rose(irq_o));
endmodule
bind pwmcc_core pwmcc_core_sva pwmcc_core_sva_i (.ref_clk_i, .rst_i, .bus_i, .rdata_o,
   .timer1_ovf_i, .gpio_out_i, .raw_wave_o, .pin_out_o, .irq_o);

// File: sim/pwmcc_core_bench.sv
// Self-checking bench of the pulse width counter control core
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module pwmcc_core_bench;
   import pwmcc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   pwmcc_bus_type bus = '0;
   logic [7:0] rdata_o;
   logic [2:0] ovf_cnt = 3'h0;
   logic [5:0] gpio;
   logic [5:0] raw;
   logic [5:0] pin;
   logic irq;
   logic pend = 1'b0;
   logic want = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] v;
   logic [7:0] exp_v;
   logic [5:0] sel;
   logic [15:0] d[6];
   logic [15:0] n0;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int hi;
   int per;
   pwmcc_core pwmcc_core_i (.ref_clk_i, .rst_i, .bus_i(bus), .rdata_o,
      .timer1_ovf_i(ovf_cnt[2]), .gpio_out_i(gpio), .raw_wave_o(raw), .pin_out_o(pin),
      .irq_o(irq));
   pwmcc_pins_model pwmcc_pins_model_i (.ref_clk_i, .gpio_out_o(gpio));
   initial forever #5 ref_clk_i = ~ref_clk_i;
   // ******************************
   // Read monitor, timer overflow and hang limit
   // ******************************
   always @(posedge ref_clk_i) begin
      if (pend) begin
         exp_v = exp_q.pop_front();
         `CHK(rdata_o, exp_v)
      end
      pend <= bus.rd && want;
      ovf_cnt <= ovf_cnt + 3'h1;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         num_errors++;
         end_of_test;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      bus <= '{a, x, 1'b1, 1'b0};
      @(posedge ref_clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic w);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      want <= w;
      @(posedge ref_clk_i);
   endtask
   task automatic rde(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      rd(a, 1'b1);
   endtask
   task automatic idle(input int n);
      bus <= '0;
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic poll_load;
      v = 8'hff;
      for (int i = 0; i < 40 && v[BIT_LOAD] !== 1'b0; i++) begin
         rd(ADDR_CTRL0, 1'b0);
         idle(1);
         v = rdata_o;
      end
      `CHK(v[BIT_LOAD], 1'b0)
   endtask
   task automatic meas(input int c);
      idle(1);
      repeat (2) begin
         while (raw[c] === 1'b1) @(posedge ref_clk_i);
         while (raw[c] !== 1'b1) @(posedge ref_clk_i);
         hi = 0;
         while (raw[c] === 1'b1) begin
            hi++;
            @(posedge ref_clk_i);
         end
         per = hi;
         while (raw[c] !== 1'b1) begin
            per++;
            @(posedge ref_clk_i);
         end
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(32'he6154f2d));
      for (int i = 0; i < 6; i++) d[i] = 16'(1 + $urandom % 9);
      sel = 6'($urandom);
      n0 = d[0] % 9 + 1;
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      rde(ADDR_CTRL0, 8'h00);
      rde(ADDR_CTRL1, 8'h00);
      rde(ADDR_CLK_SRC, 8'h00);
      rde(8'h00, 8'h00);
      wr(ADDR_CTRL0, 8'h10);
      idle(2);
      rde(ADDR_CTRL0, 8'h00);
      wr(ADDR_PER_HI, 8'h00);
      wr(ADDR_PER_LO, 8'h09);
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_DUTY_HI_BASE + 8'(i), d[i][15:8]);
         wr(ADDR_DUTY_LO_BASE + 8'(i), d[i][7:0]);
      end
      wr(ADDR_CTRL0, 8'hc0);
      poll_load;
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_CTRL1, 8'(k));
         meas(0);
         `CHK(hi, d[0] << k)
         `CHK(per, 10 << k)
      end
      for (int g = 0; g < 2; g++) begin
         wr(ADDR_CTRL1, g ? 8'h20 : 8'h00);
         for (int c = 0; c < 6; c++) begin
            meas(c);
            `CHK(hi, g && c > 1 ? d[c % 2] : d[c])
         end
      end
      wr(ADDR_CTRL1, 8'h00);
      wr(ADDR_DUTY_LO_BASE, n0[7:0]);
      meas(0);
      `CHK(hi, d[0])
      wr(ADDR_CTRL0, 8'hc0);
      poll_load;
      meas(0);
      `CHK(hi, n0)
      wr(ADDR_CLK_SRC, 8'h40);
      meas(0);
      `CHK(hi, n0 * 8)
      `CHK(per, 80)
      wr(ADDR_CLK_SRC, 8'h00);
      wr(ADDR_PIN_SEL, {2'h0, sel});
      idle(1);
      repeat (8) begin
         @(posedge ref_clk_i);
         `CHK(pin, (raw & sel) | (gpio & ~sel))
      end
      wr(ADDR_IRQ_MASK, 8'h01);
      idle(2);
      rde(ADDR_CTRL0, 8'ha0);
      wr(ADDR_CTRL0, 8'h00);
      idle(2);
      `CHK(irq, 1'b1)
      wr(ADDR_IRQ_MASK, 8'h00);
      idle(2);
      `CHK(irq, 1'b0)
      rde(ADDR_IRQ_STAT, 8'h03);
      wr(ADDR_IRQ_MASK, 8'h03);
      wr(ADDR_IRQ_STAT, 8'h03);
      idle(2);
      `CHK(irq, 1'b0)
      rde(ADDR_IRQ_STAT, 8'h00);
      wr(ADDR_CTRL0, 8'h00);
      rde(ADDR_CTRL0, 8'h00);
      rde(ADDR_PER_LO, 8'h09);
      rde(ADDR_PIN_SEL, {2'h0, sel});
      idle(2);
      end_of_test;
   end
endmodule
